// ==== core/sme_pkg.sv ====
/*
  Constants for the sync and test mode entry block: mode and state encodings,
  crystal-clock counts for the synchronisation sequence, access-code
  layout and the sequencer reset state.
  Assumes the surrounding logic samples pin levels synchronously to clk_sys_in
  and presents the single-step and high-voltage-mode pins already classified
  into normal and high-voltage levels by analogue comparators.
*/
package sme_pkg;

  // ===========================================================================
  // Sequence timing, in crystal clock or instruction cycles
  // ===========================================================================
  localparam int unsigned CLEAR_HOLD_CYC   = 4;   // Least test zero high time
  localparam int unsigned ENTER_DELAY_CYC  = 2;   // Fall to first time state
  localparam int unsigned CLK_PER_INSTR    = 15;  // Crystal clocks per instruction
  localparam int unsigned RELEASE_INSTR    = 5;   // Instruction cycles before reset
  localparam int unsigned RELEASE_WAIT_CYC = CLK_PER_INSTR * RELEASE_INSTR;

  // ===========================================================================
  // Sequencer layout
  // ===========================================================================
  localparam int unsigned PRESC_W       = 4;      // Prescaler width, counts to 14
  localparam logic [3:0]  PRESC_LAST    = 4'he;   // Last prescaler count
  localparam logic [3:0]  PRESC_RESET   = 4'h0;
  localparam int unsigned TSTATE_W      = 3;      // Time state index 0..4
  localparam logic [2:0]  TSTATE_FIRST  = 3'h0;   // Time state 1
  localparam logic [2:0]  TSTATE_LAST   = 3'h4;   // Time state 5
  localparam logic        PHASE_FIRST   = 1'b0;   // Phase 1

  // ===========================================================================
  // Access codes
  // ===========================================================================
  localparam logic [2:0]  PORT2_SPECIAL = 3'h0;   // Port 2 bits 0..2 for special
  localparam logic [7:0]  PORT1_SIG     = 8'hfe;  // Port 1 signature pattern

  // Decoded mode, one-hot
  typedef enum logic [5:0] {
    MODE_NORMAL   = 6'b00_0001,
    MODE_SYNC     = 6'b00_0010,
    MODE_PROG     = 6'b00_0100,
    MODE_VERIFY   = 6'b00_1000,
    MODE_SIG      = 6'b01_0000,
    MODE_SECURITY = 6'b10_0000
  } sme_mode_type;

  // Synchronisation sequence state, one-hot
  typedef enum logic [4:0] {
    ST_IDLE    = 5'b0_0001,   // No high voltage on single-step
    ST_ARMED   = 5'b0_0010,   // Sync mode, waiting for test zero
    ST_CLEAR   = 5'b0_0100,   // Test zero high, sequencer held
    ST_ENTER   = 5'b0_1000,   // Test zero fell, counting to phase 1
    ST_RUN     = 5'b1_0000    // Sequencer released
  } sme_state_type;

endpackage : sme_pkg

// ==== core/sme_sync_entry.sv ====
/*
  Sync and test mode entry: forces the prescaler and time-state generator
  into a known phase under tester control, decodes the special access modes
  and gates the internal run signal after reset release.
  Assumes clk_sys_in is the crystal clock input domain, all pins are sampled
  synchronously, and high-voltage levels arrive as separate comparator flags.
*/
`timescale 1ns/1ns
`default_nettype none

module sme_sync_entry #(
  parameter int unsigned RELEASE_WAIT = sme_pkg::RELEASE_WAIT_CYC
) (
  input  wire logic       clk_sys_in,          // Crystal clock domain
  input  wire logic       nrst_in,             // Async power-on reset
  input  wire logic       test_input_zero_in,  // Test zero pin level
  input  wire logic       single_step_hv_in,   // Single-step at high voltage
  input  wire logic       high_voltage_mode_pin_hv_in, // Mode pin at high voltage
  input  wire logic       reset_pin_in,        // Reset pin level, high = released
  input  wire logic [7:0] port1_in,            // Port 1 levels
  input  wire logic [2:0] port2_in,            // Port 2 bits 0..2
  output logic            sync_mode_out,       // Sync mode enabled
  output logic            seq_hold_out,        // Prescaler and states held clear
  output logic [3:0]      prescaler_out,       // Prescaler count
  output logic [2:0]      time_state_out,      // Time state, 0 = state 1
  output logic            phase_out,           // 0 = phase 1
  output logic            run_enable_out,      // Normal code execution allowed
  output logic            release_early_out,   // Reset released before the wait
  output logic [5:0]      mode_out,            // Decoded one-hot mode
  output logic            signature_sel_out    // Signature area selected
);

  // ===========================================================================
  // Sequence state
  // ===========================================================================
  sme_pkg::sme_state_type state_r, state_nxt;   // Sync sequence
  logic [6:0]             cnt_r, cnt_nxt;       // Shared cycle counter
  logic                   cleared_r, cleared_nxt; // Four clocks of clear met
  logic                   waited_r, waited_nxt; // Release wait met
  logic                   early_r, early_nxt;   // Sticky early release flag

  // Next-state for the sync sequence
  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    cleared_nxt = cleared_r;
    waited_nxt  = waited_r;
    early_nxt   = early_r;
    unique case (state_r)
      sme_pkg::ST_IDLE: begin
        // Sync needs reset low and mode pin not at high voltage
        if (single_step_hv_in && !reset_pin_in && !high_voltage_mode_pin_hv_in) begin
          state_nxt = sme_pkg::ST_ARMED;
          cnt_nxt   = '0;
        end
      end
      sme_pkg::ST_ARMED: begin
        // Tester honours the four-clock gap; we just wait for the strobe
        if (!single_step_hv_in) begin
          state_nxt = sme_pkg::ST_IDLE;
        end else if (test_input_zero_in) begin
          state_nxt   = sme_pkg::ST_CLEAR;
          cnt_nxt     = 7'd1;
          cleared_nxt = 1'b0;
        end
      end
      sme_pkg::ST_CLEAR: begin
        // Count the high time; a short pulse does not complete the clear
        if (cnt_r < 7'(sme_pkg::CLEAR_HOLD_CYC)) begin
          cnt_nxt = cnt_r + 7'd1;
        end
        if (cnt_r >= 7'(sme_pkg::CLEAR_HOLD_CYC - 1)) begin
          cleared_nxt = 1'b1;
        end
        // Only the registered flag counts: it needs four high samples already taken
        if (!test_input_zero_in) begin
          state_nxt = cleared_r ? sme_pkg::ST_ENTER : sme_pkg::ST_ARMED;
          cnt_nxt   = '0;
        end
      end
      sme_pkg::ST_ENTER: begin
        // Sequencer released on the second edge after the fall
        cnt_nxt = cnt_r + 7'd1;
        if (cnt_r == 7'(sme_pkg::ENTER_DELAY_CYC - 1)) begin
          state_nxt  = sme_pkg::ST_RUN;
          cnt_nxt    = '0;
          waited_nxt = 1'b0;
        end
      end
      sme_pkg::ST_RUN: begin
        // Single-step drop is the tester's; count the release wait from it
        if (!single_step_hv_in && !waited_r) begin
          if (cnt_r == 7'(RELEASE_WAIT - 1)) begin
            waited_nxt = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 7'd1;
          end
        end
        if (reset_pin_in && !waited_r) begin
          early_nxt = 1'b1;
        end
      end
      default: state_nxt = sme_pkg::ST_IDLE;
    endcase
  end

  // Register the sync sequence
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r   <= sme_pkg::ST_IDLE;
      cnt_r     <= '0;
      cleared_r <= 1'b0;
      waited_r  <= 1'b0;
      early_r   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      cleared_r <= cleared_nxt;
      waited_r  <= waited_nxt;
      early_r   <= early_nxt;
    end
  end

  // ===========================================================================
  // Prescaler and time-state generator
  // ===========================================================================
  logic [3:0] presc_r, presc_nxt;   // Divides crystal clock by fifteen
  logic [2:0] ts_r, ts_nxt;         // Time state within instruction
  logic       ph_r, ph_nxt;         // Phase within time state
  logic       hold;                 // Clear and hold

  // Held through clear and the two-clock entry delay
  assign hold = (state_r == sme_pkg::ST_CLEAR) || (state_r == sme_pkg::ST_ENTER);

  // Three crystal clocks per time state: phase 1 two clocks, phase 2 one
  always_comb begin
    presc_nxt = presc_r;
    ts_nxt    = ts_r;
    ph_nxt    = ph_r;
    if (hold) begin
      presc_nxt = sme_pkg::PRESC_RESET;
      ts_nxt    = sme_pkg::TSTATE_FIRST;
      ph_nxt    = sme_pkg::PHASE_FIRST;
    end else begin
      presc_nxt = (presc_r == sme_pkg::PRESC_LAST) ? sme_pkg::PRESC_RESET
                                                   : presc_r + 4'h1;
      ph_nxt    = (presc_nxt % 4'd3) == 4'd2;
      ts_nxt    = 3'(presc_nxt / 4'd3);
    end
  end

  // Register the sequencer
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      presc_r <= sme_pkg::PRESC_RESET;
      ts_r    <= sme_pkg::TSTATE_FIRST;
      ph_r    <= sme_pkg::PHASE_FIRST;
    end else begin
      presc_r <= presc_nxt;
      ts_r    <= ts_nxt;
      ph_r    <= ph_nxt;
    end
  end

  // ===========================================================================
  // Access-code decode
  // ===========================================================================
  logic [5:0] mode_r, mode_nxt;   // Registered mode
  logic       sig_r, sig_nxt;     // Signature area select

  // Special modes need port 2 low three bits zero; mode pin selects prog/verify
  always_comb begin
    sig_nxt = 1'b0;
    if (state_r != sme_pkg::ST_IDLE && single_step_hv_in) begin
      mode_nxt = sme_pkg::MODE_SYNC;
    end else if (high_voltage_mode_pin_hv_in) begin
      if (port2_in == sme_pkg::PORT2_SPECIAL) begin
        // Port 1 pattern picks signature row, else security bit/byte
        sig_nxt  = (port1_in == sme_pkg::PORT1_SIG);
        mode_nxt = sig_nxt ? sme_pkg::MODE_SIG : sme_pkg::MODE_SECURITY;
      end else begin
        // Test zero high with reset high reads back data
        mode_nxt = (test_input_zero_in && reset_pin_in) ? sme_pkg::MODE_VERIFY
                                                        : sme_pkg::MODE_PROG;
      end
    end else begin
      mode_nxt = sme_pkg::MODE_NORMAL;
    end
  end

  // Register the decode
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_r <= sme_pkg::MODE_NORMAL;
      sig_r  <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      sig_r  <= sig_nxt;
    end
  end

  // ===========================================================================
  // Outputs
  // ===========================================================================
  assign sync_mode_out     = (state_r != sme_pkg::ST_IDLE);
  assign seq_hold_out      = hold;
  assign prescaler_out     = presc_r;
  assign time_state_out    = ts_r;
  assign phase_out         = ph_r;
  // Outside sync, reset alone governs; after sync the wait must also be met
  assign run_enable_out    = reset_pin_in &&
                             ((state_r != sme_pkg::ST_RUN) ? (state_r == sme_pkg::ST_IDLE)
                                                           : waited_r);
  assign release_early_out = early_r;
  assign mode_out          = mode_r;
  assign signature_sel_out = sig_r;

endmodule : sme_sync_entry

`default_nettype wire

// ==== test/sme_tester_model.sv ====
/* Tester model: drives test zero, single-step and reset pins.
   Assumes pins change just after falling crystal clock edges. */
`timescale 1ns/1ns
`default_nettype none
module sme_tester_model (
  input  wire logic clk_in,    // Crystal clock
  output var  logic t0_out,    // Test zero pin
  output var  logic ss_hv_out, // Single-step at high voltage
  output var  logic rst_out    // Reset pin, high = released
);
  initial begin
    t0_out = 1'b0;
    ss_hv_out = 1'b0;
    rst_out = 1'b0;
  end
  // Static levels for the decode cases
  task automatic pins(input logic t, input logic r);
    @(negedge clk_in);
    t0_out = t;
    rst_out = r;
  endtask : pins
  // Whole sequence; hi and rel are allowed to break timing on purpose
  task automatic sync_seq(input int hi, input int rel);
    @(negedge clk_in);
    rst_out = 1'b0;
    ss_hv_out = 1'b1;
    repeat (4) @(negedge clk_in);
    t0_out = 1'b1;
    repeat (hi) @(negedge clk_in);
    t0_out = 1'b0;
    repeat (4) @(negedge clk_in);
    ss_hv_out = 1'b0;
    repeat (rel) @(negedge clk_in);
    rst_out = 1'b1;
  endtask : sync_seq
endmodule : sme_tester_model
`default_nettype wire

// ==== test/sme_sync_entry_checker.sv ====
/* Assertions on the top ports of the sync entry block.
   Assumes one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module sme_sync_entry_checker #(
  parameter int unsigned RELEASE_WAIT = 75
) (
  input wire logic       clk_sys_in,
  input wire logic       nrst_in,
  input wire logic       test_input_zero_in,
  input wire logic       single_step_hv_in,
  input wire logic       high_voltage_mode_pin_hv_in,
  input wire logic       reset_pin_in,
  input wire logic [7:0] port1_in,
  input wire logic [2:0] port2_in,
  input wire logic       sync_mode_out,
  input wire logic       seq_hold_out,
  input wire logic [3:0] prescaler_out,
  input wire logic [2:0] time_state_out,
  input wire logic       phase_out,
  input wire logic       run_enable_out,
  input wire logic       release_early_out,
  input wire logic [5:0] mode_out,
  input wire logic       signature_sel_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);
  // ====================================================
  // Helpers: in run phase, cycles since single-step left HV
  logic       in_run_r;
  logic [7:0] wait_r;
  // A refused pulse holds at most three cycles, an accepted one at least six
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      in_run_r <= 1'b0;
      wait_r   <= 8'h00;
    end else begin
      in_run_r <= in_run_r | ($fell(seq_hold_out) & $past(seq_hold_out, 4));
      if (in_run_r && !single_step_hv_in && wait_r != 8'hff) begin
        wait_r <= wait_r + 8'h01;
      end
    end
  end
  sequence long_hi;
    (seq_hold_out && test_input_zero_in) [*4] ##1 !test_input_zero_in;
  endsequence
  sequence short_hi;
    sync_mode_out && !seq_hold_out && !test_input_zero_in
      ##1 test_input_zero_in [*2] ##1 !test_input_zero_in;
  endsequence
  sequence three_hi;
    sync_mode_out && !seq_hold_out && !test_input_zero_in
      ##1 test_input_zero_in [*3] ##1 !test_input_zero_in;
  endsequence
  sync_arm_a: assert property (
    $rose(sync_mode_out) |-> $past(single_step_hv_in) && !$past(reset_pin_in)
      && !$past(high_voltage_mode_pin_hv_in)) else $error("sync arm");
  clear_entry_a: assert property (
    long_hi |-> ##1 seq_hold_out ##1 seq_hold_out ##1 !seq_hold_out) else $error("entry");
  short_refused_a: assert property (
    short_hi |-> ##1 !seq_hold_out) else $error("short pulse");
  three_refused_a: assert property (
    three_hi |-> ##1 !seq_hold_out) else $error("three cycle pulse");
  first_state_a: assert property (
    $fell(seq_hold_out) && $past(seq_hold_out, 4) |-> $past(test_input_zero_in, 4)
      && prescaler_out == 4'h0 && time_state_out == 3'h0 && !phase_out)
    else $error("first state");
  state_map_a: assert property (
    in_run_r |-> time_state_out == prescaler_out / 4'h3
      && phase_out == (prescaler_out % 4'h3 == 4'h2)) else $error("state map");
  presc_step_a: assert property (
    in_run_r |=> prescaler_out == (($past(prescaler_out) == 4'he) ? 4'h0
      : $past(prescaler_out) + 4'h1)) else $error("prescaler step");
  sync_decode_a: assert property (
    sync_mode_out && single_step_hv_in |=> mode_out == 6'h02) else $error("sync decode");
  run_gate_a: assert property (
    in_run_r && run_enable_out |-> wait_r >= RELEASE_WAIT - 2) else $error("run gate");
  early_flag_a: assert property (
    in_run_r && reset_pin_in && !single_step_hv_in && wait_r < RELEASE_WAIT - 2
      |=> release_early_out) else $error("early flag");
  sig_decode_a: assert property (
    !sync_mode_out && !single_step_hv_in && high_voltage_mode_pin_hv_in
      && port2_in == 3'h0 && port1_in == 8'hfe
      |=> mode_out == 6'h10 && signature_sel_out) else $error("signature");
endmodule : sme_sync_entry_checker
bind sme_sync_entry sme_sync_entry_checker #(.RELEASE_WAIT(RELEASE_WAIT)) i_chk (.*);
`default_nettype wire

// ==== test/sme_sync_entry_bench.sv ====
/* Bench: decode rows, then short, boundary and full sync sequences.
   Assumes the tester model drives test zero, single-step and reset. */
`timescale 1ns/1ns
`default_nettype none
module sme_sync_entry_bench;
  logic            clk_sys_in = 1'b0;
  logic            nrst_in = 1'b0;
  logic            high_voltage_mode_pin_hv_in = 1'b0;
  logic [7:0]      port1_in = 8'h00;
  logic [2:0]      port2_in = 3'h0;
  wire logic       test_input_zero_in, single_step_hv_in, reset_pin_in, sync_mode_out;
  wire logic       seq_hold_out, phase_out, run_enable_out, release_early_out;
  wire logic       signature_sel_out;
  wire logic [3:0] prescaler_out;
  wire logic [2:0] time_state_out;
  wire logic [5:0] mode_out;
  int              fail_count = 0;
  int              total_checks = 0;
  logic [19:0]     rows [5];     // hv, t0, rst, port1, port2, mode
  always #2 clk_sys_in = ~clk_sys_in;
  sme_sync_entry i_sme_sync_entry (.*);
  sme_tester_model i_sme_tester_model (.clk_in(clk_sys_in), .t0_out(test_input_zero_in),
    .ss_hv_out(single_step_hv_in), .rst_out(reset_pin_in));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  initial begin
    rows[0] = {3'b000, 8'h00, 3'h1, sme_pkg::MODE_NORMAL};
    rows[1] = {3'b100, 8'h00, 3'h1, sme_pkg::MODE_PROG};
    rows[2] = {3'b111, 8'h00, 3'h1, sme_pkg::MODE_VERIFY};
    rows[3] = {3'b100, 8'hfe, 3'h0, sme_pkg::MODE_SIG};
    rows[4] = {3'b100, 8'h00, 3'h0, sme_pkg::MODE_SECURITY};
    repeat (5) @(negedge clk_sys_in);
    check("mode", sme_pkg::MODE_NORMAL, mode_out);
    nrst_in = 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      i_sme_tester_model.pins(rows[i][18], rows[i][17]);
      high_voltage_mode_pin_hv_in = rows[i][19];
      port1_in = rows[i][16:9];
      port2_in = rows[i][8:6];
      @(negedge clk_sys_in);
      check("mode", rows[i][5:0], mode_out);
      check("sig", rows[i][5:0] == sme_pkg::MODE_SIG, signature_sel_out);
    end
    $display("test decode done");
    i_sme_tester_model.pins(1'b0, 1'b0);
    high_voltage_mode_pin_hv_in = 1'b0;
    // Two high cycles of test zero must be refused
    i_sme_tester_model.sync_seq(2, 3);
    check("hold", 1'b0, seq_hold_out);
    check("sync", 1'b0, sync_mode_out);
    // Three high cycles is one short of the clear and must be refused too
    i_sme_tester_model.sync_seq(3, 3);
    check("hold", 1'b0, seq_hold_out);
    check("sync", 1'b0, sync_mode_out);
    $display("test short pulse done");
    // Exactly four high cycles enter; reset then released too soon
    i_sme_tester_model.sync_seq(4, 20);
    check("presc", 4'h6, prescaler_out);
    check("state", 3'h2, time_state_out);
    @(negedge clk_sys_in);
    check("early", 1'b1, release_early_out);
    check("run", 1'b0, run_enable_out);
    nrst_in = 1'b0;
    @(negedge clk_sys_in);
    nrst_in = 1'b1;
    $display("test early release done");
    i_sme_tester_model.sync_seq(5, 82);
    #1;
    check("presc", 4'h8, prescaler_out);
    check("phase", 1'b1, phase_out);
    check("run", 1'b1, run_enable_out);
    check("early", 1'b0, release_early_out);
    $display("test full sync done");
    results();
  end
  // Run needs about 180 cycles; 2500 means a hang
  initial begin
    #10000;
    fail_count++;
    results();
  end
endmodule : sme_sync_entry_bench
`default_nettype wire
